// file: shared/atp_defines.svh
// offsets, field positions, reset values and sizes of the access protection checker
// assumes a 12-bit byte address on the register bus and 32-bit words
`ifndef ATP_DEFINES_SVH
`define ATP_DEFINES_SVH

// register map (byte addresses)
`define ATP_BOUND_BASE    12'h000   // 4 sets x 16 words, words 0..11 used per set
`define ATP_BOUND_TOP     12'h0FF   // last byte of the bound window
`define ATP_BOUND_WORDS   4'hC      // used words per set: 6 ranges x lower/upper
`define ATP_MODE_BASE     12'h100   // one mode word per set, 0x100..0x10C
`define ATP_STATUS        12'h120   // sticky trap events, read only
`define ATP_CLEAR         12'h124   // write one to clear status bits, write only
`define ATP_IRQ_EN        12'h128   // interrupt enable, same layout as status
`define ATP_VIOL_ADDR     12'h12C   // address of the last rejected access
`define ATP_VIOL_INFO     12'h130   // trap kind and set of the last rejected access

// mode word fields
`define ATP_MODE_RD_LSB   0         // data range r read grant at bit 2r
`define ATP_MODE_WR_LSB   1         // data range r write grant at bit 2r+1
`define ATP_MODE_X_LSB    8         // code range c fetch grant at bit 8+c
`define ATP_MODE_EN_LSB   16        // range k enable at bit 16+k (data 0..3, code 4..5)

// status bit positions
`define ATP_ST_PRIV       0
`define ATP_ST_READ       1
`define ATP_ST_WRITE      2
`define ATP_ST_EXEC       3
`define ATP_ST_BITS       4

// reset values
`define ATP_RST_WORD      32'h0000_0000
`define ATP_RST_STATUS    4'h0

// address space layout
`define ATP_PRIV_SEG_LO   4'hE      // segments 14 and 15 are privileged in physical mode
`define ATP_PAGE_BITS     12        // offset bits kept through page translation

`endif

// file: shared/atp_pkg.sv
// types shared by the access protection checker and its surroundings
// assumes the defines header is included by users that need numbers
package atp_pkg;

    // kind of processor access
    typedef enum logic [1:0] {
        ATP_ACC_READ  = 2'b00,
        ATP_ACC_WRITE = 2'b01,
        ATP_ACC_FETCH = 2'b10
    } atp_acc_e;

    // privilege level of the issuing task
    typedef enum logic [1:0] {
        ATP_PRIV_USER0 = 2'b00,
        ATP_PRIV_USER1 = 2'b01,
        ATP_PRIV_SUPER = 2'b10
    } atp_priv_e;

    // trap raised instead of completing the access
    typedef enum logic [2:0] {
        ATP_TRAP_NONE  = 3'b000,
        ATP_TRAP_PRIV  = 3'b001,
        ATP_TRAP_READ  = 3'b010,
        ATP_TRAP_WRITE = 3'b011,
        ATP_TRAP_EXEC  = 3'b100
    } atp_trap_e;

    // access request from fetch or load/store, with the page entry already looked up
    typedef struct packed {
        logic         valid;
        atp_acc_e     kind;
        atp_priv_e    priv;
        logic         virt_mode;
        logic [1:0]   protection_set_select;
        logic [31:0]  vaddr;
        logic [19:0]  pte_frame;
        logic         page_execute_enable;
        logic         page_write_enable;
        logic         page_read_enable;
    } atp_req_s;

    // verdict for one request
    typedef struct packed {
        logic         valid;
        logic [31:0]  paddr;
        logic         via_pte;
        atp_trap_e    trap;
    } atp_resp_s;

endpackage

// file: hdl/atp_check.sv
// access protection checker: translation choice, range and page checks, trap signalling
// assumes requests come from logic on pclk and the page entry is valid with the request
//
// Local design decisions: the placing of the registers and the APB register port.
`timescale 1ns/1ns
`include "atp_defines.svh"

module atp_check #(
    parameter int NUM_SETS   = 4,   // protection register sets
    parameter int DATA_RANGES = 4,  // ranges in the data part of a set
    parameter int CODE_RANGES = 2   // ranges in the code part of a set
) (
    // clock, reset, enable
    input  wire logic                pclk,
    input  wire logic                presetn,
    input  wire logic                ce,
    // register bus
    input  wire logic                psel,
    input  wire logic                penable,
    input  wire logic                pwrite,
    input  wire logic [11:0]         paddr,
    input  wire logic [31:0]         pwdata,
    output      logic [31:0]         prdata,
    output      logic                pready,
    output      logic                pslverr,
    // processor access path
    input  wire atp_pkg::atp_req_s   req,
    output      atp_pkg::atp_resp_s  resp,
    // debug trace
    output      logic                dbg_viol,
    output      logic [31:0]         dbg_addr,
    output      atp_pkg::atp_trap_e  dbg_trap,
    // interrupt
    output      logic                irq
);

    localparam int NR = DATA_RANGES + CODE_RANGES;  // ranges per set

    ////////////////////////////////////////////////////////////////////////////////
    // storage

    logic [31:0]              bound_lo [NUM_SETS][NR];   // inclusive lower bounds
    logic [31:0]              bound_hi [NUM_SETS][NR];   // exclusive upper bounds
    logic [31:0]              mode     [NUM_SETS];       // grants and enables per set
    logic [`ATP_ST_BITS-1:0]  status;                    // sticky trap events
    logic [`ATP_ST_BITS-1:0]  irq_en;                    // interrupt enables
    logic [31:0]              viol_addr;                 // last rejected address
    logic [4:0]               viol_info;                 // trap kind and set of it

    ////////////////////////////////////////////////////////////////////////////////
    // bus decode

    logic        setup;          // setup phase of a transfer
    logic        wr_take;        // write lands at this edge
    logic        in_bound;       // address hits a used word of the bound window
    logic [1:0]  b_set;          // set addressed in the bound window
    logic [3:0]  b_word;         // word inside that set
    logic [2:0]  b_range;        // range addressed
    logic        in_mode;        // address hits a mode word
    logic        mapped;         // any register decodes
    logic [31:0] rd_mux;         // read value before registering

    assign setup    = psel & ~penable;
    assign wr_take  = psel & penable & pready & pwrite & ~pslverr;
    assign b_set    = paddr[7:6];
    assign b_word   = paddr[5:2];
    assign b_range  = b_word[3:1];
    assign in_bound = (paddr <= `ATP_BOUND_TOP) && (b_word < `ATP_BOUND_WORDS);
    assign in_mode  = (paddr[11:4] == `ATP_MODE_BASE >> 4) && (paddr[1:0] == 2'b00);

    // decode and read selection; unaligned or unmapped addresses are refused
    always_comb
    begin
        mapped = 1'b1;
        rd_mux = `ATP_RST_WORD;
        if (paddr[1:0] != 2'b00)
        begin
            mapped = 1'b0;                    // only whole words exist
        end
        else if (in_bound)
        begin
            rd_mux = b_word[0] ? bound_hi[b_set][b_range] : bound_lo[b_set][b_range];
        end
        else if (in_mode)
        begin
            rd_mux = mode[paddr[3:2]];
        end
        else
        begin
            case (paddr)
                `ATP_STATUS:    rd_mux = {28'h0000000, status};
                `ATP_CLEAR:     rd_mux = `ATP_RST_WORD;    // write only, reads zero
                `ATP_IRQ_EN:    rd_mux = {28'h0000000, irq_en};
                `ATP_VIOL_ADDR: rd_mux = viol_addr;
                `ATP_VIOL_INFO: rd_mux = {27'h0000000, viol_info};
                default:        mapped = 1'b0;
            endcase
        end
    end

    // one access cycle: answer is prepared in setup, shown with pready in access
    always_ff @(posedge pclk or negedge presetn)
    begin
        if (!presetn)
        begin
            pready  <= 1'b0;
            pslverr <= 1'b0;
            prdata  <= `ATP_RST_WORD;
        end
        else if (ce)
        begin
            pready  <= setup;
            pslverr <= setup & ~mapped;
            if (setup & ~pwrite)
            begin
                prdata <= mapped ? rd_mux : `ATP_RST_WORD;
            end
        end
    end

    ////////////////////////////////////////////////////////////////////////////////
    // protection register writes

    // bound pairs, one per range and set, and mode words, one per set
    always_ff @(posedge pclk or negedge presetn)
    begin
        if (!presetn)
        begin
            for (int s = 0; s < NUM_SETS; s++)
            begin
                mode[s] <= `ATP_RST_WORD;
                for (int k = 0; k < NR; k++)
                begin
                    bound_lo[s][k] <= `ATP_RST_WORD;
                    bound_hi[s][k] <= `ATP_RST_WORD;
                end
            end
        end
        else if (ce && wr_take)
        begin
            if (in_bound)
            begin
                if (b_word[0])
                    bound_hi[b_set][b_range] <= pwdata;
                else
                    bound_lo[b_set][b_range] <= pwdata;
            end
            else if (in_mode)
            begin
                mode[paddr[3:2]] <= pwdata;
            end
        end
    end

    // interrupt enables
    always_ff @(posedge pclk or negedge presetn)
    begin
        if (!presetn)
            irq_en <= `ATP_RST_STATUS;
        else if (ce && wr_take && paddr == `ATP_IRQ_EN)
            irq_en <= pwdata[`ATP_ST_BITS-1:0];
    end

    ////////////////////////////////////////////////////////////////////////////////
    // translation choice

    logic [3:0]  seg;        // segment of the virtual address
    logic        upper;      // address in the upper half
    logic        use_pte;    // lower half in virtual mode goes through the page entry
    logic [31:0] phys;       // physical address handed on
    logic [1:0]  act_set;    // active protection set

    assign seg     = req.vaddr[31:28];
    assign upper   = seg[3];
    assign use_pte = req.virt_mode & ~upper;
    assign act_set = req.protection_set_select;
    // direct translation keeps the address, page translation swaps the frame
    assign phys    = use_pte ? {req.pte_frame, req.vaddr[`ATP_PAGE_BITS-1:0]}
                             : req.vaddr;

    ////////////////////////////////////////////////////////////////////////////////
    // range checks, one per range of the active set

    logic [NR-1:0] grant;    // range contains the address and grants this kind

    generate
        for (genvar k = 0; k < NR; k++)
        begin : g_range
            logic hit;   // enabled and containing
            logic ok;    // mode grants this access kind
            assign hit = mode[act_set][`ATP_MODE_EN_LSB + k]
                       && (phys >= bound_lo[act_set][k])
                       && (phys <  bound_hi[act_set][k]);
            if (k < DATA_RANGES)
            begin : g_data
                // data ranges never grant a fetch, so code and data stay apart
                always_comb
                begin
                    case (req.kind)
                        atp_pkg::ATP_ACC_READ:  ok = mode[act_set][`ATP_MODE_RD_LSB + 2*k];
                        atp_pkg::ATP_ACC_WRITE: ok = mode[act_set][`ATP_MODE_WR_LSB + 2*k];
                        default:                ok = 1'b0;
                    endcase
                end
            end
            else
            begin : g_code
                // code ranges grant only fetches
                assign ok = (req.kind == atp_pkg::ATP_ACC_FETCH)
                          && mode[act_set][`ATP_MODE_X_LSB + k - DATA_RANGES];
            end
            assign grant[k] = hit & ok;
        end
    endgenerate

    ////////////////////////////////////////////////////////////////////////////////
    // verdict

    logic               range_ok;    // some range permits the access
    logic               pte_ok;      // page entry permits the access
    logic               u0_block;    // user0 touches a privileged address
    atp_pkg::atp_trap_e verdict;     // trap for this request

    assign range_ok = |grant;
    // user0 may not reach privileged space; the mode decides what that space is
    assign u0_block = (req.priv == atp_pkg::ATP_PRIV_USER0)
                    && (req.virt_mode ? upper
                                      : (seg >= `ATP_PRIV_SEG_LO));

    // page bits pick the permission of the access kind
    always_comb
    begin
        case (req.kind)
            atp_pkg::ATP_ACC_FETCH: pte_ok = req.page_execute_enable;
            atp_pkg::ATP_ACC_WRITE: pte_ok = req.page_write_enable;
            atp_pkg::ATP_ACC_READ:  pte_ok = req.page_read_enable;
            default:                pte_ok = 1'b0;
        endcase
    end

    // privilege violation outranks the permission checks
    always_comb
    begin
        verdict = atp_pkg::ATP_TRAP_NONE;
        if (u0_block)
            verdict = atp_pkg::ATP_TRAP_PRIV;
        else if (use_pte ? !pte_ok : !range_ok)
        begin
            case (req.kind)
                atp_pkg::ATP_ACC_FETCH: verdict = atp_pkg::ATP_TRAP_EXEC;
                atp_pkg::ATP_ACC_WRITE: verdict = atp_pkg::ATP_TRAP_WRITE;
                default:                verdict = atp_pkg::ATP_TRAP_READ;
            endcase
        end
    end

    // answer to the core one cycle after the request
    always_ff @(posedge pclk or negedge presetn)
    begin
        if (!presetn)
            resp <= '0;
        else if (ce)
        begin
            resp.valid   <= req.valid;
            resp.paddr   <= phys;
            resp.via_pte <= use_pte;
            // the core runs the trap handler routine instead of the access
            resp.trap    <= req.valid ? verdict : atp_pkg::ATP_TRAP_NONE;
        end
    end

    ////////////////////////////////////////////////////////////////////////////////
    // debug trace

    logic bad;   // rejected request this cycle
    assign bad = req.valid && (verdict != atp_pkg::ATP_TRAP_NONE);

    // pulse with the offending address for the debug unit
    always_ff @(posedge pclk or negedge presetn)
    begin
        if (!presetn)
        begin
            dbg_viol <= 1'b0;
            dbg_addr <= `ATP_RST_WORD;
            dbg_trap <= atp_pkg::ATP_TRAP_NONE;
        end
        else if (ce)
        begin
            dbg_viol <= bad;
            if (bad)
            begin
                dbg_addr <= req.vaddr;
                dbg_trap <= verdict;
            end
        end
    end

    // last violation kept for software; a later one overwrites it
    always_ff @(posedge pclk or negedge presetn)
    begin
        if (!presetn)
        begin
            viol_addr <= `ATP_RST_WORD;
            viol_info <= 5'h00;
        end
        else if (ce && bad)
        begin
            viol_addr <= req.vaddr;
            viol_info <= {act_set, verdict};
        end
    end

    ////////////////////////////////////////////////////////////////////////////////
    // status and interrupt

    logic [`ATP_ST_BITS-1:0] ev;    // event of this cycle
    logic [`ATP_ST_BITS-1:0] clr;   // bits software clears this cycle

    always_comb
    begin
        ev = `ATP_RST_STATUS;
        if (bad)
        begin
            case (verdict)
                atp_pkg::ATP_TRAP_PRIV:  ev[`ATP_ST_PRIV]  = 1'b1;
                atp_pkg::ATP_TRAP_READ:  ev[`ATP_ST_READ]  = 1'b1;
                atp_pkg::ATP_TRAP_WRITE: ev[`ATP_ST_WRITE] = 1'b1;
                atp_pkg::ATP_TRAP_EXEC:  ev[`ATP_ST_EXEC]  = 1'b1;
                default:                 ev = `ATP_RST_STATUS;
            endcase
        end
    end

    assign clr = (wr_take && paddr == `ATP_CLEAR) ? pwdata[`ATP_ST_BITS-1:0] : `ATP_RST_STATUS;

    // sticky bits; a new event beats a clear in the same cycle so none is lost
    always_ff @(posedge pclk or negedge presetn)
    begin
        if (!presetn)
            status <= `ATP_RST_STATUS;
        else if (ce)
            status <= (status & ~clr) | ev;
    end

    // level interrupt, registered so the output comes straight from a flop
    always_ff @(posedge pclk or negedge presetn)
    begin
        if (!presetn)
            irq <= 1'b0;
        else if (ce)
            irq <= |(((status & ~clr) | ev) & irq_en);
    end

endmodule

// file: verif/atp_check_chk.sv
// port assertions for the access protection checker
// assumes it is bound onto atp_check, one pclk domain
`timescale 1ns/1ns
module atp_check_chk #(
    parameter int NUM_SETS    = 4,
    parameter int DATA_RANGES = 4,
    parameter int CODE_RANGES = 2
) (
    // clock, reset and enable
    input wire logic               pclk,
    input wire logic               presetn,
    input wire logic               ce,
    // register bus handshake
    input wire logic               psel,
    input wire logic               penable,
    input wire logic               pready,
    // access path and trace
    input wire atp_pkg::atp_req_s  req,
    input wire atp_pkg::atp_resp_s resp,
    input wire logic               dbg_viol,
    input wire logic [31:0]        dbg_addr,
    input wire atp_pkg::atp_trap_e dbg_trap
);
    logic pg; // request translated through the page entry
    logic rq; // qualified request this cycle
    assign rq = ce && req.valid;
    assign pg = rq && req.virt_mode && !req.vaddr[31];
    default clocking cb @(posedge pclk); endclocking
    default disable iff (!presetn);
    ////////////////////////////////////////////////////////////
    valid_follow_a: assert property (ce |=> resp.valid == $past(req.valid))
        else $error("resp valid does not follow req valid");
    idle_quiet_a: assert property (ce && !req.valid |=> resp.trap == atp_pkg::ATP_TRAP_NONE && !dbg_viol)
        else $error("trap raised without request");
    direct_pass_a: assert property (rq && !pg |=> resp.paddr == $past(req.vaddr) && !resp.via_pte)
        else $error("direct address altered");
    page_xlat_a: assert property (pg |=> resp.via_pte &&
        resp.paddr == ({$past(req.pte_frame), 12'h000} | ($past(req.vaddr) & 32'h0000_0FFF)))
        else $error("page translation wrong");
    priv_virt_a: assert property (rq && req.priv == atp_pkg::ATP_PRIV_USER0 && req.virt_mode
        && req.vaddr[31] |=> resp.trap == atp_pkg::ATP_TRAP_PRIV) else $error("user0 upper half not rejected");
    priv_phys_a: assert property (rq && req.priv == atp_pkg::ATP_PRIV_USER0 && !req.virt_mode
        && req.vaddr[31:28] >= 4'hE |=> resp.trap == atp_pkg::ATP_TRAP_PRIV)
        else $error("user0 seg 14/15 not rejected");
    no_priv_a: assert property (rq && req.priv != atp_pkg::ATP_PRIV_USER0
        |=> resp.trap != atp_pkg::ATP_TRAP_PRIV)
        else $error("address trap for privileged task");
    page_exec_a: assert property (pg && req.kind == atp_pkg::ATP_ACC_FETCH |=> resp.trap ==
        ($past(req.page_execute_enable) ? atp_pkg::ATP_TRAP_NONE : atp_pkg::ATP_TRAP_EXEC)) else $error("page fetch");
    page_write_a: assert property (pg && req.kind == atp_pkg::ATP_ACC_WRITE |=> resp.trap ==
        ($past(req.page_write_enable) ? atp_pkg::ATP_TRAP_NONE : atp_pkg::ATP_TRAP_WRITE)) else $error("page write");
    page_read_a: assert property (pg && req.kind == atp_pkg::ATP_ACC_READ
        && req.priv != atp_pkg::ATP_PRIV_USER0
        |=> resp.trap == ($past(req.page_read_enable) ? atp_pkg::ATP_TRAP_NONE : atp_pkg::ATP_TRAP_READ))
        else $error("page read");
    dbg_pulse_a: assert property (rq |=> dbg_viol == (resp.trap != atp_pkg::ATP_TRAP_NONE))
        else $error("trace pulse missing");
    dbg_info_a: assert property (dbg_viol |-> dbg_trap == resp.trap && dbg_addr == $past(req.vaddr))
        else $error("trace content wrong");
    bus_ready_a: assert property (ce && psel && !penable |=> pready ##1 !pready)
        else $error("pready not one access cycle");
endmodule
bind atp_check atp_check_chk #(.NUM_SETS(NUM_SETS), .DATA_RANGES(DATA_RANGES), .CODE_RANGES(CODE_RANGES)) i_chk (
    .pclk(pclk), .presetn(presetn), .ce(ce), .psel(psel), .penable(penable), .pready(pready),
    .req(req), .resp(resp), .dbg_viol(dbg_viol), .dbg_addr(dbg_addr), .dbg_trap(dbg_trap));

// file: verif/atp_core_model.sv
// fetch and load/store side: issues one request, returns its verdict
// assumes the checker answers one cycle after taking a request
`timescale 1ns/1ns
module atp_core_model (
    // clock
    input wire logic               pclk,
    // access path
    output     atp_pkg::atp_req_s  req,
    input wire atp_pkg::atp_resp_s resp
);
    initial req = '0;
    ////////////////////////////////////////////////////////////
    // drive after an edge, hold one cycle, then scramble the idle bus
    // so a stale address can never pass for a fresh one
    task automatic issue(input atp_pkg::atp_req_s r, output atp_pkg::atp_resp_s s);
        atp_pkg::atp_req_s idle;
        @(posedge pclk);
        req <= r;
        @(posedge pclk);
        idle = atp_pkg::atp_req_s'(~r);
        idle.valid = 1'b0;
        req <= idle;
        #1;
        s = resp;
    endtask
endmodule

// file: verif/test_address_translation_protection_check.sv
// self-checking bench for the access protection checker
// assumes the checker is bound and the core model drives req
`timescale 1ns/1ns
`include "atp_defines.svh"
module test_address_translation_protection_check;
    logic pclk, presetn, ce, psel, penable, pwrite, pready, pslverr, irq, dbg_viol;
    logic [11:0]        paddr;      // register byte address
    logic [31:0]        pwdata, prdata, dbg_addr;
    atp_pkg::atp_req_s  req;        // from the core model
    atp_pkg::atp_resp_s resp;
    atp_pkg::atp_trap_e dbg_trap;
    int                 miscompares = 0;
    int                 checked = 0;
    localparam logic [19:0] FR = 20'hABCDE; // frame for every page entry
    atp_check i_dut (.pclk(pclk), .presetn(presetn), .ce(ce), .psel(psel), .penable(penable),
        .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready),
        .pslverr(pslverr), .req(req), .resp(resp), .dbg_viol(dbg_viol), .dbg_addr(dbg_addr),
        .dbg_trap(dbg_trap), .irq(irq));
    atp_core_model i_core (.pclk(pclk), .req(req), .resp(resp));
    ////////////////////////////////////////////////////////////
    task automatic test_done();
        $display("checked %0d miscompares %0d", checked, miscompares);
        if (miscompares == 0 && checked > 0)
            $display("TEST PASSED");
        else
            $display("TEST FAILED");
        $finish;
    endtask
    task automatic cmp(input string n, input logic [31:0] e, input logic [31:0] g);
        checked++;
        if (g !== e)
        begin
            miscompares++;
            $display("ERROR %s expected %h seen %h", n, e, g);
        end
    endtask
    // one apb transfer; the request holds until pready is seen high
    task automatic apb(input logic w, input logic [11:0] a, input logic [31:0] d,
                       output logic [31:0] q, output logic e);
        @(posedge pclk);
        psel <= 1'b1;
        penable <= 1'b0;
        pwrite <= w;
        paddr <= a;
        pwdata <= d;
        @(posedge pclk);
        penable <= 1'b1;
        // look at each edge; the answer is taken at the edge that sees pready
        do
            @(posedge pclk);
        while (pready !== 1'b1);
        q = prdata;
        e = pslverr;
        psel <= 1'b0;
        penable <= 1'b0;
    endtask
    task automatic wr(input logic [11:0] a, input logic [31:0] d);
        logic [31:0] q;
        logic        e;
        apb(1'b1, a, d, q, e);
        cmp("pslverr", 32'h0, 32'(e));
    endtask
    task automatic rd(input logic [11:0] a, input logic [31:0] x);
        logic [31:0] q;
        logic        e;
        apb(1'b0, a, 32'h0, q, e);
        cmp("pslverr", 32'h0, 32'(e));
        cmp("prdata", x, q);
    endtask
    // one access: kind, priv, virt, set, address, page bits xwr, expected trap
    task automatic acc(input logic [1:0] k, input logic [1:0] pv, input logic vm, input logic [1:0] ps,
                       input logic [31:0] va, input logic [2:0] xwr, input logic [2:0] et);
        atp_pkg::atp_req_s  r;
        atp_pkg::atp_resp_s s;
        r = '{1'b1, atp_pkg::atp_acc_e'(k), atp_pkg::atp_priv_e'(pv), vm, ps, va, FR, xwr[2], xwr[1], xwr[0]};
        i_core.issue(r, s);
        cmp("trap", 32'(et), 32'(s.trap));
        cmp("paddr", (vm && !va[31]) ? {FR, va[11:0]} : va, s.paddr);
        cmp("dbg_viol", 32'(et != 3'h0), 32'(dbg_viol));
        if (et != 3'h0)
            cmp("dbg_trap", 32'(et), 32'(dbg_trap));
    endtask
    ////////////////////////////////////////////////////////////
    task automatic t_regs();
        logic [31:0] q;
        logic        e;
        rd(`ATP_STATUS, 32'h0);
        rd(`ATP_IRQ_EN, 32'h0);
        rd(`ATP_MODE_BASE, 32'h0);
        rd(`ATP_CLEAR, 32'h0);
        apb(1'b0, 12'h0F0, 32'h0, q, e); // unmapped word of set 3
        cmp("unmapped pslverr", 32'h1, 32'(e));
        cmp("unmapped prdata", 32'h0, q);
    endtask
    // set 2: data range 1 read only, data range 3 disabled, code range 0 fetch
    task automatic t_range();
        wr(12'h088, 32'h2000_0000);
        wr(12'h08C, 32'h2000_1000);
        wr(12'h098, 32'h0000_0000);
        wr(12'h09C, 32'hFFFF_FFFF);
        wr(12'h0A0, 32'h8000_0000);
        wr(12'h0A4, 32'h8000_0100);
        wr(`ATP_MODE_BASE + 12'h008, 32'h0012_0184);
        rd(`ATP_MODE_BASE + 12'h008, 32'h0012_0184);
        acc(2'h0, 2'h2, 1'b0, 2'h2, 32'h2000_0000, 3'h0, 3'h0);
        acc(2'h0, 2'h2, 1'b0, 2'h2, 32'h2000_0FFC, 3'h0, 3'h0);
        acc(2'h0, 2'h2, 1'b0, 2'h2, 32'h2000_1000, 3'h0, 3'h2);
        acc(2'h1, 2'h2, 1'b0, 2'h2, 32'h2000_0010, 3'h0, 3'h3);
        acc(2'h2, 2'h2, 1'b0, 2'h2, 32'h2000_0010, 3'h0, 3'h4);
        acc(2'h2, 2'h2, 1'b0, 2'h2, 32'h8000_00FC, 3'h0, 3'h0);
        acc(2'h0, 2'h2, 1'b0, 2'h2, 32'h8000_0000, 3'h0, 3'h2);
        acc(2'h2, 2'h2, 1'b0, 2'h2, 32'h8000_0100, 3'h0, 3'h4);
        acc(2'h0, 2'h2, 1'b0, 2'h0, 32'h2000_0000, 3'h0, 3'h2);
    endtask
    // each kind with its page bit set and with only the other two set
    task automatic t_page();
        logic [1:0] k;
        logic [2:0] b;
        for (int i = 0; i < 6; i++)
        begin
            k = 2'(i / 2);
            b = 3'h1 << k;
            acc(k, 2'h2, 1'b1, 2'h0, 32'h1234_5678, i[0] ? b : ~b, i[0] ? 3'h0 : 3'(k) + 3'h2);
        end
    endtask
    task automatic t_priv();
        acc(2'h0, 2'h0, 1'b1, 2'h2, 32'h9000_0000, 3'h7, 3'h1);
        acc(2'h0, 2'h0, 1'b1, 2'h2, 32'h1000_0000, 3'h1, 3'h0);
        acc(2'h0, 2'h0, 1'b0, 2'h2, 32'hE000_0000, 3'h0, 3'h1);
        acc(2'h2, 2'h0, 1'b0, 2'h2, 32'hF000_0000, 3'h0, 3'h1);
        acc(2'h0, 2'h0, 1'b0, 2'h2, 32'hD000_0000, 3'h0, 3'h2);
        acc(2'h0, 2'h1, 1'b0, 2'h2, 32'hF000_0000, 3'h0, 3'h2);
        acc(2'h0, 2'h2, 1'b1, 2'h2, 32'h9000_0000, 3'h0, 3'h2);
    endtask
    // sticky status, enable mask, write-one clear, last violation record
    task automatic t_irq();
        rd(`ATP_STATUS, 32'h0000_000F);
        cmp("irq masked", 32'h0, 32'(irq));
        wr(`ATP_IRQ_EN, 32'h0000_0001);
        @(posedge pclk); // irq sees the new enable one edge after it lands
        #1;
        cmp("irq enabled", 32'h1, 32'(irq));
        wr(`ATP_CLEAR, 32'h0000_0001);
        #1;
        cmp("irq cleared", 32'h0, 32'(irq));
        rd(`ATP_STATUS, 32'h0000_000E);
        acc(2'h0, 2'h0, 1'b0, 2'h2, 32'hE000_0010, 3'h0, 3'h1);
        cmp("irq event", 32'h1, 32'(irq));
        rd(`ATP_VIOL_ADDR, 32'hE000_0010);
        rd(`ATP_VIOL_INFO, 32'h0000_0011);
        wr(`ATP_CLEAR, 32'h0000_000F);
        rd(`ATP_STATUS, 32'h0);
        cmp("irq idle", 32'h0, 32'(irq));
    endtask
    ////////////////////////////////////////////////////////////
    initial
    begin
        pclk = 1'b0;
        forever #5 pclk = ~pclk;
    end
    // watchdog: the run needs well under a thousand cycles
    initial
    begin
        #200000;
        miscompares++;
        test_done();
    end
    initial
    begin
        presetn = 1'b0;
        ce = 1'b1;
        psel = 1'b0;
        penable = 1'b0;
        pwrite = 1'b0;
        paddr = 12'h000;
        pwdata = 32'h0;
        repeat (2) @(posedge pclk);
        presetn <= 1'b1;
        t_regs();
        t_range();
        t_page();
        t_priv();
        t_irq();
        test_done();
    end
endmodule
